/* design/sirqp_pkg.sv */
// shared constants and types for the serial interrupt peripheral
package sirqp_pkg;

   localparam int unsigned SIRQP_CLK_PERIOD_NS = 25;
   localparam int unsigned SIRQP_NUM_SLOTS     = 32;
   localparam logic [3:0]  SIRQP_STOP_QUIET_W  = 4'h2;
   localparam logic [3:0]  SIRQP_STOP_MIN_W    = 4'h2;
   localparam logic [3:0]  SIRQP_LOW_CNT_MAX   = 4'hf;
   localparam logic [5:0]  SIRQP_SLOT_RST      = 6'h00;

   typedef enum logic {SIRQP_CONT, SIRQP_QUIET} sirqp_mode_e;
   typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_START, ST_SLOTS, ST_STOP} sirqp_state_e;
   typedef enum logic [1:0] {PH_SAMP, PH_REC, PH_TA} sirqp_phase_e;

   localparam sirqp_mode_e SIRQP_MODE_RST = SIRQP_CONT;

endpackage

/* design/sirqp_sync.sv */
// two-stage synchroniser for asynchronous interrupt levels
`timescale 1ns/1ps
module sirqp_sync #(
   parameter int unsigned W = 1
)(
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   // levels
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   import sirqp_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sirqp_sync_s;

   sirqp_sync_s st_ff;
   sirqp_sync_s nxt_st;

   always_comb
   begin
      nxt_st    = st_ff;
      nxt_st.s1 = d_i;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign q_o = st_ff.s2;

endmodule // sirqp_sync

/* design/sirqp_dev.sv */
// peripheral end of the serial interrupt link
`timescale 1ns/1ps
module sirqp_dev #(
   parameter int unsigned                NUM_SLOTS = sirqp_pkg::SIRQP_NUM_SLOTS,
   parameter logic [NUM_SLOTS-1:0]       OWN_SLOTS = '1
)(
   // clock and master reset
   input  wire logic                 clk_i,
   input  wire logic                 nrst_i,
   // interrupt levels, slot 1 in bit 0
   input  wire logic [NUM_SLOTS-1:0] irq_level_i,
   // shared open-drain line
   input  wire logic                 serial_interrupt_line_i,
   output logic                      serial_interrupt_line_o,
   output logic                      serial_interrupt_line_oe_n_o,
   // status
   output logic                      quiet_mode_o,
   output logic                      cycle_active_o
);
   import sirqp_pkg::*;

   localparam int unsigned IW   = (NUM_SLOTS > 1) ? $clog2(NUM_SLOTS) : 1;
   localparam logic [5:0]  LAST = 6'(NUM_SLOTS);

   typedef struct packed {
      sirqp_state_e         state;
      sirqp_mode_e          mode;
      sirqp_phase_e         phase;
      logic [5:0]           slot;
      logic [3:0]           low_cnt;
      logic [NUM_SLOTS-1:0] rep;
      logic                 out;
      logic                 oe_n;
      logic                 act;
   } sirqp_dev_s;

   sirqp_dev_s           st_ff;
   sirqp_dev_s           nxt_st;
   logic [NUM_SLOTS-1:0] irq_s;
   logic                 line;
   logic                 pending;
   logic [IW-1:0]        idx_cur;
   logic [IW-1:0]        idx_new;

   // line is timed by this same clock, so it is read directly
   assign line = serial_interrupt_line_i;

   sirqp_sync #(
      .W      (NUM_SLOTS)
   ) u_sync (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .d_i    (irq_level_i),
      .q_o    (irq_s)
   );

   assign pending = |((irq_s ^ st_ff.rep) & OWN_SLOTS);
   assign idx_cur = IW'(st_ff.slot - 6'h01);
   assign idx_new = IW'(st_ff.slot);

   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.oe_n = 1'b1;
      nxt_st.out  = 1'b1;
      unique case (st_ff.state)
         ST_IDLE:
         begin
            if (!line)
               nxt_st.state = ST_START;
            // continuous mode never reaches the request branch
            else if (st_ff.mode == SIRQP_QUIET && pending)
            begin
               nxt_st.state = ST_REQ;
               nxt_st.oe_n  = 1'b0;
               nxt_st.out   = 1'b0;
            end
         end
         ST_REQ:
            nxt_st.state = ST_START;
         ST_START:
         begin
            // first high clock is the start frame's recovery, t = 0
            if (line)
            begin
               nxt_st.state = ST_SLOTS;
               nxt_st.phase = PH_TA;
               nxt_st.slot  = SIRQP_SLOT_RST;
            end
         end
         ST_SLOTS:
         begin
            unique case (st_ff.phase)
               PH_SAMP:
               begin
                  nxt_st.phase = PH_REC;
                  if (OWN_SLOTS[idx_cur])
                  begin
                     nxt_st.oe_n = 1'b0;
                     nxt_st.out  = 1'b1;
                  end
               end
               PH_REC:
                  nxt_st.phase = PH_TA;
               PH_TA:
               begin
                  if (st_ff.slot == LAST)
                  begin
                     nxt_st.state   = ST_STOP;
                     nxt_st.low_cnt = '0;
                  end
                  else
                  begin
                     // slot k samples at clock 3k-1 after the start edge
                     nxt_st.phase = PH_SAMP;
                     nxt_st.slot  = st_ff.slot + 6'h01;
                     if (OWN_SLOTS[idx_new])
                     begin
                        nxt_st.rep[idx_new] = irq_s[idx_new];
                        if (irq_s[idx_new])
                        begin
                           nxt_st.oe_n = 1'b0;
                           nxt_st.out  = 1'b0;
                        end
                     end
                  end
               end
               default:
                  nxt_st.state = ST_IDLE;
            endcase
         end
         ST_STOP:
         begin
            if (!line)
            begin
               if (st_ff.low_cnt != SIRQP_LOW_CNT_MAX)
                  nxt_st.low_cnt = st_ff.low_cnt + 4'h1;
            end
            // a single low clock is not a stop; keep waiting
            else if (st_ff.low_cnt >= SIRQP_STOP_MIN_W)
            begin
               nxt_st.state = ST_IDLE;
               nxt_st.mode  = (st_ff.low_cnt == SIRQP_STOP_QUIET_W) ?
                              SIRQP_QUIET : SIRQP_CONT;
            end
         end
      endcase
      nxt_st.act = (nxt_st.state != ST_IDLE);
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_ff         <= '0;
         st_ff.state   <= ST_IDLE;
         st_ff.mode    <= SIRQP_MODE_RST;
         st_ff.phase   <= PH_SAMP;
         st_ff.slot    <= SIRQP_SLOT_RST;
         st_ff.out     <= 1'b1;
         st_ff.oe_n    <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   assign serial_interrupt_line_o      = st_ff.out;
   assign serial_interrupt_line_oe_n_o = st_ff.oe_n;
   assign quiet_mode_o                 = (st_ff.mode == SIRQP_QUIET);
   assign cycle_active_o               = st_ff.act;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   chk_req_one_clk: assert property (
      st_ff.state == ST_REQ |-> !st_ff.oe_n && !st_ff.out ##1 st_ff.oe_n)
      else $error("quiet start pulse not exactly one clock");
   chk_cont_no_req: assert property (
      $rose(st_ff.state == ST_REQ) |-> $past(st_ff.mode) == SIRQP_QUIET)
      else $error("start request issued in continuous mode");
   chk_reset_mode: assert property (
      $rose(nrst_i) |-> st_ff.mode == SIRQP_CONT && st_ff.state == ST_IDLE)
      else $error("reset did not leave continuous idle");
   chk_start_edge: assert property (
      (st_ff.state == ST_START && line) |=> st_ff.oe_n ##1
      (st_ff.slot == 6'h01 && st_ff.phase == PH_SAMP))
      else $error("slot one not two clocks after start edge");
   chk_three_phase: assert property (
      (st_ff.state == ST_SLOTS && st_ff.phase == PH_SAMP) |=>
      st_ff.phase == PH_REC ##1 st_ff.phase == PH_TA)
      else $error("slot phases out of order");
   chk_sample_low: assert property (
      (st_ff.state == ST_SLOTS && st_ff.phase == PH_SAMP && !st_ff.oe_n) |->
      !st_ff.out && st_ff.rep[idx_cur])
      else $error("sample phase drive does not match reported level");
   chk_recover_high: assert property (
      (st_ff.state == ST_SLOTS && st_ff.phase == PH_SAMP && !st_ff.oe_n) |=>
      (!st_ff.oe_n && st_ff.out) ##1 st_ff.oe_n)
      else $error("recovery not driven high after sample");
   chk_ta_release: assert property (
      (st_ff.state == ST_SLOTS && st_ff.phase == PH_TA) |-> st_ff.oe_n)
      else $error("line driven in turn-around");
   chk_last_slot: assert property (
      (st_ff.state == ST_SLOTS && st_ff.slot == LAST && st_ff.phase == PH_TA) |=>
      st_ff.state == ST_STOP)
      else $error("cycle did not stop after last slot");
   chk_stop_quiet: assert property (
      (st_ff.state == ST_STOP && line && st_ff.low_cnt == 4'h2) |=>
      st_ff.mode == SIRQP_QUIET && st_ff.state == ST_IDLE)
      else $error("two clock stop did not select quiet");
   chk_stop_cont: assert property (
      (st_ff.state == ST_STOP && line && st_ff.low_cnt == 4'h3) |=>
      st_ff.mode == SIRQP_CONT && st_ff.state == ST_IDLE)
      else $error("three clock stop did not select continuous");
   chk_req_cause: assert property (
      $rose(st_ff.state == ST_REQ) |-> $past(pending) && $past(line))
      else $error("start request without change or on busy line");

   cov_quiet_req:   cover property (st_ff.state == ST_REQ);
   cov_slot_drive:  cover property (st_ff.phase == PH_SAMP && !st_ff.oe_n);
   cov_quiet_stop:  cover property (st_ff.state == ST_STOP ##1 st_ff.mode == SIRQP_QUIET);

endmodule // sirqp_dev

/* tb/sirqp_host.sv */
// host end model of the serial interrupt link
`timescale 1ns/1ps
module sirqp_host (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // control from the bench
   input  wire logic       go_i,
   input  wire logic [3:0] start_w_i,
   input  wire logic [3:0] stop_w_i,
   // shared open-drain line, pulled up
   input  wire logic       line_i,
   output logic            out_o,
   output logic            oe_n_o,
   // slot levels as the host has collected them
   output logic [31:0]     seen_o
);
   int st_ff;
   int cnt_ff;
   // everything moves on the rising edge only, like every driver on the line
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_ff  <= 0;
         cnt_ff <= 0;
         // inactive defaults stand until the first cycle starts
         seen_o <= '0;
         out_o  <= 1'b1;
         oe_n_o <= 1'b1;
      end
      else
      begin
         case (st_ff)
            0: if (go_i || !line_i)
            begin
               out_o  <= 1'b0;
               oe_n_o <= 1'b0;
               // a device start already used one low clock
               cnt_ff <= go_i ? int'(start_w_i) : int'(start_w_i) - 1;
               st_ff  <= 1;
            end
            1, 3: if (cnt_ff == 1)
            begin
               out_o  <= 1'b1;
               cnt_ff <= 0;
               st_ff  <= st_ff + 1;
            end
            else
               cnt_ff <= cnt_ff - 1;
            2:
            begin
               oe_n_o <= 1'b1;
               cnt_ff <= cnt_ff + 1;
               // slot k is sampled in clock 3k-1 after the start edge
               if (cnt_ff % 3 == 2 && cnt_ff <= 95)
                  seen_o[(cnt_ff + 1) / 3 - 1] <= !line_i;
               if (cnt_ff == 97)
               begin
                  out_o  <= 1'b0;
                  oe_n_o <= 1'b0;
                  cnt_ff <= int'(stop_w_i);
                  st_ff  <= 3;
               end
            end
            default:
            begin
               oe_n_o <= 1'b1;
               st_ff  <= 0;
            end
         endcase
      end
   end
endmodule // sirqp_host

/* tb/test_sirqp_dev.sv */
// self-checking bench for the serial interrupt peripheral
`timescale 1ns/1ps
module test_sirqp_dev;
   import sirqp_pkg::*;
   logic        clk_i  = 1'b0;
   logic        nrst_i = 1'b0;
   logic [31:0] lvl    = '0;
   logic        go     = 1'b0;
   logic [3:0]  sw     = 4'h4;
   logic [3:0]  pw     = 4'h2;
   logic        q_exp  = 1'b0;
   logic        d_out, d_oe_n, h_out, h_oe_n, quiet, active;
   logic [31:0] h_seen;
   wire         line   = (d_oe_n | d_out) & (h_oe_n | h_out);
   int          mismatches  = 0;
   int          comparisons = 0;
   int          seed        = 32'h6447;
   int          n;

   always #12.5 clk_i = ~clk_i;

   sirqp_dev sirqp_dev_i (.clk_i(clk_i), .nrst_i(nrst_i), .irq_level_i(lvl),
      .serial_interrupt_line_i(line), .serial_interrupt_line_o(d_out),
      .serial_interrupt_line_oe_n_o(d_oe_n), .quiet_mode_o(quiet), .cycle_active_o(active));
   sirqp_host sirqp_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go), .start_w_i(sw),
      .stop_w_i(pw), .line_i(line), .out_o(h_out), .oe_n_o(h_oe_n), .seen_o(h_seen));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   task automatic final_report;
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic line_idle;
      repeat (8)
      begin
         @(negedge clk_i);
         check(line, 1'b1, "unexpected start");
      end
   endtask

   // slot timing is reckoned from the first high clock after the start pulse
   task automatic run_cycle(input logic by_dev);
      n = 0;
      while (line && n < 20)
      begin
         @(negedge clk_i);
         n++;
      end
      check(d_oe_n, !by_dev, "start owner");
      @(negedge clk_i);
      check(d_oe_n, 1'b1, "start not released");
      while (!line && n < 40)
      begin
         @(negedge clk_i);
         n++;
      end
      check({n < 40, active}, 2'b11, "start frame");
      repeat (2) @(negedge clk_i);
      for (int k = 1; k <= 32; k++)
      begin
         check(line, !lvl[k-1], "sample phase");
         @(negedge clk_i);
         check({d_oe_n, line}, 2'b01, "recovery phase");
         @(negedge clk_i);
         check(d_oe_n, 1'b1, "turn-around phase");
         @(negedge clk_i);
      end
      repeat (pw + 3) @(negedge clk_i);
      q_exp = (pw == 4'h2);
      check({quiet, active}, {q_exp, 1'b0}, "stop width mode");
      check(h_seen, lvl, "host view of levels");
   endtask

   initial
   begin
      repeat (2) @(negedge clk_i);
      nrst_i = 1'b1;
      check({quiet, d_oe_n, active}, 3'b010, "reset state");
      for (int i = 0; i < 6; i++)
      begin
         line_idle();
         // bit 0 always flips so a quiet-mode request is guaranteed
         lvl = lvl ^ ($random(seed) | 32'h1);
         sw = 4'h4 + 4'({$random(seed)} % 5);
         // the host only ever stops with 2 or 3 low clocks
         pw = 4'h2 + 4'(i % 2);
         if (!q_exp)
         begin
            line_idle();
            go = 1'b1;
            @(negedge clk_i);
            go = 1'b0;
         end
         run_cycle(q_exp);
      end
      // the last stop leaves the link in continuous mode before the run ends
      check(quiet, 1'b0, "not continuous at end");
      final_report();
   end

   initial
   begin
      #(25 * 3000);
      mismatches++;
      final_report();
   end
endmodule // test_sirqp_dev
